// ===== inc/dcr_consts.vh
// Constants for the data acquisition card I/O register decode
// Function
// - In software start mode each write of 1 to the trigger bit runs exactly one conversion; writes while a conversion is busy are dropped.
// - Offset 0xE0 is the write-only gain and channel select; reads return reserved content.
// - Offset 0xE8 is the write-only trigger; reads return reserved content and start nothing.
// - Offset 0x2A holds the interrupt polarity control, readable and writable.
// - Offset 0x05 holds the interrupt mask control, readable and writable.
// - A read of offset 0x07 returns the present state of the auxiliary pins.
// - Bit 0 of the status at 0xEC goes to 1 when a conversion completes, 0 while not valid.
// - The output converter latch updates only on the high byte write, low byte first.
`ifndef DCR_CONSTS_VH
`define DCR_CONSTS_VH

`define DCR_OFS_RESET      8'h00
`define DCR_OFS_AUX_CTL    8'h02
`define DCR_OFS_AUX_DATA   8'h03
`define DCR_OFS_INT_MASK   8'h05
`define DCR_OFS_AUX_PINS   8'h07
`define DCR_OFS_INT_POL    8'h2A
`define DCR_OFS_TMR0       8'hC0
`define DCR_OFS_TMR1       8'hC4
`define DCR_OFS_TMR2       8'hC8
`define DCR_OFS_TMR_CTL    8'hCC
`define DCR_OFS_CONV_LO    8'hD0
`define DCR_OFS_CONV_HI    8'hD4
`define DCR_OFS_DIO_LO     8'hD8
`define DCR_OFS_DIO_HI     8'hDC
`define DCR_OFS_GAIN_MUX   8'hE0
`define DCR_OFS_MODE       8'hE4
`define DCR_OFS_TRIGGER    8'hE8
`define DCR_OFS_STATUS     8'hEC

`define DCR_BIT_SW_START   0
`define DCR_BIT_TIMED      1
`define DCR_BIT_TRIGGER    0
`define DCR_BIT_READY      0

`define DCR_RESERVED_RD    8'h00
`define DCR_RST_REG8       8'h00
`define DCR_RST_MODE       8'h00

`endif

// ===== src/dcr_conv_seq.v
// Conversion sequencer: one start pulse per request taken while idle, ready flag, result latch
`timescale 1ns/1ps
`include "dcr_consts.vh"
module dcr_conv_seq (
  input  wire        clk,
  input  wire        reset,
  input  wire        startReq,
  input  wire        convDone,
  input  wire [11:0] convData,
  output reg         convStart_r,
  output reg         busy_r,
  output reg         ready_r,
  output reg  [11:0] result_r
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_BUSY = 2'b10;

  reg [1:0] state_r;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (reset) begin
      state_r     <= ST_IDLE;
      convStart_r <= 1'b0;
      busy_r      <= 1'b0;
      ready_r     <= 1'b0;
      result_r    <= 12'h000;
    end else begin
      convStart_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          // Requests while busy are dropped so each start yields one result
          if (startReq) begin
            convStart_r <= 1'b1;
            busy_r      <= 1'b1;
            ready_r     <= 1'b0;
            state_r     <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (convDone) begin
            result_r <= convData;
            ready_r  <= 1'b1;
            busy_r   <= 1'b0;
            state_r  <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          busy_r  <= 1'b0;
        end
      endcase
    end
  end

endmodule // dcr_conv_seq

// ===== src/dcr_io_decode.v
// I/O register decode of the data acquisition card
`timescale 1ns/1ps
`include "dcr_consts.vh"
module dcr_io_decode (
  input  wire        clk,
  input  wire        reset,
  input  wire [7:0]  ioAddr,
  input  wire        ioWr,
  input  wire        ioRd,
  input  wire [7:0]  ioWrData,
  output reg  [7:0]  ioRdData_r,
  output reg         ioRdValid_r,
  input  wire [7:0]  auxPins,
  input  wire [15:0] diIn,
  input  wire        convDone,
  input  wire [11:0] convData,
  input  wire        timedTick,
  input  wire [7:0]  timerRdData,
  output reg  [1:0]  timerSel_r,
  output reg  [7:0]  timerWrData_r,
  output reg         timerWrStb_r,
  output reg         timerRdStb_r,
  output reg  [7:0]  boardReset_r,
  output reg  [7:0]  auxCtl_r,
  output reg  [7:0]  auxData_r,
  output reg  [7:0]  intMask_r,
  output reg  [7:0]  intPolarity_r,
  output reg  [11:0] dacOut_r,
  output reg  [15:0] doOut_r,
  output reg  [1:0]  amplifierCode_r,
  output reg  [3:0]  channelSelect_r,
  output reg         softwareStartEnable_r,
  output reg         timedStartEnable_r,
  output reg         convStart_r
);

  // Address compare, used by the trigger start request decode
  function isAt;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      isAt = (addr == ofs);
    end
  endfunction

  reg  [7:0] dacLow_r;
  reg        startReq;
  wire       seqStart;
  wire       seqBusy;
  wire       seqReady;
  wire [11:0] seqResult;
  wire       wrEn;
  wire       rdEn;

  assign wrEn = ioWr & ~ioRd;
  assign rdEn = ioRd & ~ioWr;

  ////////////////////////////////////////////////////////////////////////////
  // Start request: software trigger only in software mode, tick in timed mode
  always @* begin
    startReq = 1'b0;
    if (wrEn && isAt(ioAddr, `DCR_OFS_TRIGGER) &&
        ioWrData[`DCR_BIT_TRIGGER] && softwareStartEnable_r)
      startReq = 1'b1;
    else if (timedTick && timedStartEnable_r)
      startReq = 1'b1;
  end

  dcr_conv_seq u_seq (
    .clk         (clk),
    .reset       (reset),
    .startReq    (startReq),
    .convDone    (convDone),
    .convData    (convData),
    .convStart_r (seqStart),
    .busy_r      (seqBusy),
    .ready_r     (seqReady),
    .result_r    (seqResult)
  );

  always @(posedge clk) begin
    if (reset)
      convStart_r <= 1'b0;
    else
      convStart_r <= seqStart;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write side
  always @(posedge clk) begin
    if (reset) begin
      boardReset_r          <= `DCR_RST_REG8;
      auxCtl_r              <= `DCR_RST_REG8;
      auxData_r             <= `DCR_RST_REG8;
      intMask_r             <= `DCR_RST_REG8;
      intPolarity_r         <= `DCR_RST_REG8;
      dacLow_r              <= `DCR_RST_REG8;
      dacOut_r              <= 12'h000;
      doOut_r               <= 16'h0000;
      amplifierCode_r       <= 2'b00;
      channelSelect_r       <= 4'h0;
      softwareStartEnable_r <= 1'b0;
      timedStartEnable_r    <= 1'b0;
      timerSel_r            <= 2'b00;
      timerWrData_r         <= 8'h00;
      timerWrStb_r          <= 1'b0;
    end else begin
      timerWrStb_r <= 1'b0;
      if (wrEn) begin
        case (ioAddr)
          `DCR_OFS_RESET:    boardReset_r  <= ioWrData;
          `DCR_OFS_AUX_CTL:  auxCtl_r      <= ioWrData;
          `DCR_OFS_AUX_DATA: auxData_r     <= ioWrData;
          `DCR_OFS_INT_MASK: intMask_r     <= ioWrData;
          `DCR_OFS_INT_POL:  intPolarity_r <= ioWrData;
          `DCR_OFS_TMR0, `DCR_OFS_TMR1, `DCR_OFS_TMR2,
          `DCR_OFS_TMR_CTL: begin
            timerSel_r    <= ioAddr[3:2];
            timerWrData_r <= ioWrData;
            timerWrStb_r  <= 1'b1;
          end
          `DCR_OFS_CONV_LO:  dacLow_r <= ioWrData;
          `DCR_OFS_CONV_HI:  dacOut_r <= {ioWrData[3:0], dacLow_r};
          `DCR_OFS_DIO_LO:   doOut_r[7:0]  <= ioWrData;
          `DCR_OFS_DIO_HI:   doOut_r[15:8] <= ioWrData;
          `DCR_OFS_GAIN_MUX: begin
            amplifierCode_r <= ioWrData[1:0];
            channelSelect_r <= ioWrData[5:2];
          end
          `DCR_OFS_MODE: begin
            softwareStartEnable_r <= ioWrData[`DCR_BIT_SW_START];
            timedStartEnable_r    <= ioWrData[`DCR_BIT_TIMED];
          end
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read side; answer one cycle after the read strobe
  always @(posedge clk) begin
    if (reset) begin
      ioRdData_r   <= 8'h00;
      ioRdValid_r  <= 1'b0;
      timerRdStb_r <= 1'b0;
    end else begin
      ioRdValid_r  <= rdEn;
      timerRdStb_r <= 1'b0;
      if (rdEn) begin
        case (ioAddr)
          `DCR_OFS_RESET:    ioRdData_r <= boardReset_r;
          `DCR_OFS_AUX_CTL:  ioRdData_r <= auxCtl_r;
          `DCR_OFS_AUX_DATA: ioRdData_r <= auxData_r;
          `DCR_OFS_INT_MASK: ioRdData_r <= intMask_r;
          `DCR_OFS_AUX_PINS: ioRdData_r <= auxPins;
          `DCR_OFS_INT_POL:  ioRdData_r <= intPolarity_r;
          `DCR_OFS_TMR0, `DCR_OFS_TMR1, `DCR_OFS_TMR2: begin
            ioRdData_r   <= timerRdData;
            timerRdStb_r <= 1'b1;
          end
          `DCR_OFS_CONV_LO:  ioRdData_r <= seqResult[7:0];
          `DCR_OFS_CONV_HI:  ioRdData_r <= {4'h0, seqResult[11:8]};
          `DCR_OFS_DIO_LO:   ioRdData_r <= diIn[7:0];
          `DCR_OFS_DIO_HI:   ioRdData_r <= diIn[15:8];
          `DCR_OFS_STATUS:
            ioRdData_r <= {7'h00, seqReady};
          // Write-only and unmapped offsets read reserved, no side effect
          default:           ioRdData_r <= `DCR_RESERVED_RD;
        endcase
      end
    end
  end

endmodule // dcr_io_decode

// ===== verification/dcr_io_decode_asserts.sv
// Checker for the I/O register decode ports
`timescale 1ns/1ps
module dcr_io_decode_asserts (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [7:0]  ioAddr,
  input wire logic        ioWr,
  input wire logic        ioRd,
  input wire logic [7:0]  ioWrData,
  input wire logic [7:0]  ioRdData_r,
  input wire logic        ioRdValid_r,
  input wire logic [7:0]  auxPins,
  input wire logic [7:0]  intMask_r,
  input wire logic [7:0]  intPolarity_r,
  input wire logic [11:0] dacOut_r,
  input wire logic [15:0] doOut_r,
  input wire logic [1:0]  amplifierCode_r,
  input wire logic [3:0]  channelSelect_r,
  input wire logic        convStart_r
);
  wire wr = ioWr & ~ioRd;
  wire rd = ioRd & ~ioWr;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_read_valid: assert property (rd |=> ioRdValid_r)
    else $error("read not answered");
  a_aux_read: assert property (rd && ioAddr == 8'h07 |=>
    ioRdData_r == $past(auxPins))
    else $error("aux pin read wrong");
  a_gain_rsvd: assert property (rd && ioAddr == 8'hE0 |=>
    ioRdData_r == 8'h00)
    else $error("gain read not reserved");
  a_trig_rsvd: assert property (rd && ioAddr == 8'hE8 |=>
    ioRdData_r == 8'h00)
    else $error("trigger read not reserved");
  a_gain_load: assert property (wr && ioAddr == 8'hE0 |=>
    {2'b00, channelSelect_r, amplifierCode_r} == ($past(ioWrData) & 8'h3F))
    else $error("gain select not loaded");
  a_pol_load: assert property (wr && ioAddr == 8'h2A |=>
    intPolarity_r == $past(ioWrData))
    else $error("polarity not loaded");
  a_mask_load: assert property (wr && ioAddr == 8'h05 |=>
    intMask_r == $past(ioWrData))
    else $error("mask not loaded");
  a_dac_hold: assert property (wr && ioAddr == 8'hD0 |=>
    $stable(dacOut_r))
    else $error("dac moved on low byte");
  a_dac_load: assert property (wr && ioAddr == 8'hD4 |=>
    {4'h0, dacOut_r[11:8]} == ($past(ioWrData) & 8'h0F))
    else $error("dac high not loaded");
  a_do_load: assert property (wr && ioAddr == 8'hD8 |=>
    doOut_r[7:0] == $past(ioWrData))
    else $error("digital out not loaded");
  a_start_pulse: assert property (convStart_r |=> !convStart_r)
    else $error("start longer than one cycle");
  c_start: cover property (convStart_r);
  c_dac: cover property (wr && ioAddr == 8'hD4);
  c_aux: cover property (rd && ioAddr == 8'h07);
endmodule // dcr_io_decode_asserts

bind dcr_io_decode dcr_io_decode_asserts chk (.clk, .reset, .ioAddr, .ioWr,
  .ioRd, .ioWrData, .ioRdData_r, .ioRdValid_r, .auxPins, .intMask_r,
  .intPolarity_r, .dacOut_r, .doOut_r, .amplifierCode_r, .channelSelect_r,
  .convStart_r);

// ===== verification/dcr_conv_model.sv
// Converter model: answers each start with one result after LAT cycles
`timescale 1ns/1ps
module dcr_conv_model #(parameter int LAT = 8) (
  input wire logic         clk,
  input wire logic         start,
  output logic             done,
  output logic [11:0]      data
);
  int          cnt = 0;
  logic [11:0] val = 12'hA5C;
  initial begin
    done = 1'b0;
    data = 12'h000;
  end
  // Data lines show the inverse outside the done pulse
  always @(posedge clk) begin
    done <= 1'b0;
    data <= ~val;
    if (start) begin
      cnt <= LAT;
    end else if (cnt == 1) begin
      done <= 1'b1;
      data <= val;
      val <= val + 12'h111;
      cnt <= 0;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule // dcr_conv_model

// ===== verification/test_daq_card_io_register_decode.sv
// Self-checking bench for the I/O register decode
`timescale 1ns/1ps
module test_daq_card_io_register_decode;
  logic        clk = 0, reset = 1, ioWr = 0, ioRd = 0;
  logic        convDone, ioRdValid_r, softwareStartEnable_r, convStart_r;
  logic [7:0]  ioAddr = 0, ioWrData = 0, auxPins = 0, ioRdData_r;
  logic [15:0] diIn = 0, doOut_r;
  logic [11:0] convData, dacOut_r, res = 12'hA5C;
  logic [3:0]  channelSelect_r;
  logic [1:0]  amplifierCode_r;
  logic        timedTick = 0;
  logic [7:0]  auxCtl_r, boardReset_r;
  int          bad_count = 0, cmp_count = 0, starts = 0, i;
  dcr_io_decode uut (.clk, .reset, .ioAddr, .ioWr, .ioRd, .ioWrData,
    .ioRdData_r, .ioRdValid_r, .auxPins, .diIn, .convDone, .convData,
    .timedTick, .timerRdData(8'h00), .timerSel_r(), .timerWrData_r(),
    .timerWrStb_r(), .timerRdStb_r(), .boardReset_r, .auxCtl_r,
    .auxData_r(), .intMask_r(), .intPolarity_r(), .dacOut_r, .doOut_r,
    .amplifierCode_r, .channelSelect_r, .softwareStartEnable_r,
    .timedStartEnable_r(), .convStart_r);
  dcr_conv_model #(.LAT(8)) conv (.clk, .start(convStart_r),
    .done(convDone), .data(convData));
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) if (convStart_r === 1'b1) starts <= starts + 1;
  ////////////////////////////////////////////////////////////////////////
  task chk(input string n, input [15:0] e, input [15:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    ioAddr = a;
    ioWrData = d;
    ioWr = 1;
    @(posedge clk);
    #1 ioWr = 0;
    @(posedge clk);
    #1;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    ioAddr = a;
    ioRd = 1;
    @(posedge clk);
    #1 ioRd = 0;
    chk("valid", 1, ioRdValid_r);
    chk($sformatf("read %h", a), e, ioRdData_r);
    @(posedge clk);
    #1;
  endtask
  task waitconv;
    i = 0;
    while (convDone !== 1'b1 && i < 50) begin
      @(negedge clk);
      i++;
    end
    chk("done", 1, convDone);
    repeat (2) @(posedge clk);
    #1;
  endtask
  task print_verdict;
    $display("Comparisons %0d, errors %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    #1 reset = 0;
    rd(8'h05, 8'h00);
    wr(8'h05, 8'hA5);
    wr(8'h2A, 8'h03);
    rd(8'h05, 8'hA5);
    rd(8'h2A, 8'h03);
    wr(8'h02, 8'h5A);
    chk("auxctl", 16'h005A, auxCtl_r);
    rd(8'h02, 8'h5A);
    wr(8'h00, 8'h81);
    chk("brdreset", 16'h0081, boardReset_r);
    rd(8'h00, 8'h81);
    auxPins = 8'h3C;
    wr(8'h07, 8'hFF);
    rd(8'h07, 8'h3C);
    wr(8'hE0, 8'h37);
    chk("gain", 16'h0037, {channelSelect_r, amplifierCode_r});
    rd(8'hE0, 8'h00);
    wr(8'hE8, 8'h01);
    wr(8'hE4, 8'hF1);
    chk("swmode", 1, softwareStartEnable_r);
    rd(8'hE4, 8'h00);
    wr(8'hE8, 8'h02);
    rd(8'hE8, 8'h00);
    rd(8'hEC, 8'h00);
    chk("starts", 0, starts);
    wr(8'hE8, 8'h01);
    rd(8'hEC, 8'h00);
    waitconv;
    rd(8'hEC, 8'h01);
    rd(8'hD0, res[7:0]);
    rd(8'hD4, {4'h0, res[11:8]});
    chk("starts", 1, starts);
    res = res + 12'h111;
    wr(8'hE8, 8'h01);
    wr(8'hE8, 8'h01);
    waitconv;
    rd(8'hD0, res[7:0]);
    chk("starts", 2, starts);
    wr(8'hD0, 8'h9A);
    chk("dac", 16'h0000, dacOut_r);
    wr(8'hD4, 8'h05);
    chk("dac", 16'h059A, dacOut_r);
    wr(8'hD8, 8'hA1);
    wr(8'hDC, 8'hB2);
    chk("dout", 16'hB2A1, doOut_r);
    diIn = 16'h1234;
    rd(8'hD8, 8'h34);
    rd(8'hDC, 8'h12);
    wr(8'hE4, 8'hF2);
    chk("swmode", 0, softwareStartEnable_r);
    wr(8'hE8, 8'h01);
    repeat (4) @(posedge clk);
    #1 chk("starts", 2, starts);
    timedTick = 1;
    @(posedge clk);
    #1 timedTick = 0;
    waitconv;
    res = res + 12'h111;
    rd(8'hD0, res[7:0]);
    chk("starts", 3, starts);
    rd(8'h10, 8'h00);
    print_verdict;
  end
  initial begin
    #20us;
    bad_count++;
    $display("Error watchdog expected end seen hang");
    print_verdict;
  end
endmodule // test_daq_card_io_register_decode
